// ### core/riot_core.sv
/*
  riot_core: RAM, two 8-bit ports, interval timer and interrupt flags
  behind the host select, address, read/write and data lines.
  Assumes all inputs synchronous to ref_clk_i; one access per cycle that the
  host presents the strobe access_i; open-drain pins are given as output
  plus enable and the wire is resolved outside.
*/
`timescale 1ns/1ps
module riot_core #(
  parameter int RAM_DEPTH = riot_pkg::RIOT_RAM_DEPTH // RAM bytes
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic access_i, // one-cycle host access strobe
  input wire riot_pkg::riot_bus_s bus_i,
  input wire logic [riot_pkg::RIOT_DATA_W-1:0] port_a_i, // port A pin levels
  input wire logic [riot_pkg::RIOT_DATA_W-1:0] port_b_i, // unused: B reads its register
  output logic [riot_pkg::RIOT_DATA_W-1:0] rdata_o,
  output logic rdata_oe_o, // high while the data bus is driven
  output riot_pkg::riot_port_s port_a_o,
  output riot_pkg::riot_port_s port_b_o,
  output logic irq_n_o, // open-drain level, always low when driven
  output logic irq_oe_o // high while pulling the request low
);
  import riot_pkg::*;

  // refuse a depth that the 7-bit byte address cannot cover exactly
  if (RAM_DEPTH != RIOT_RAM_DEPTH) begin : g_bad_depth
    $error("RAM depth must match the 7-bit address");
  end

  // decode
  logic chip_sel; // both chip selects active
  logic ram_sel;
  logic io_sel; // I/O section
  logic tmr_sel; // timer section
  logic tmr_wr; // timer load
  logic tmr_rd; // timer read
  logic flg_rd; // flag read
  logic edg_wr; // edge control write
  logic io_wr; // port register write
  logic [RIOT_ADDR_W-1:0] addr;

  // address decode of one access
  always_comb begin
    addr = bus_i.byte_address_lines;
    chip_sel = access_i & bus_i.chip_select_high & ~bus_i.chip_select_low_n;
    ram_sel = chip_sel & ~bus_i.section_select_n;
    io_sel = chip_sel & bus_i.section_select_n & ~addr[RIOT_A_TIMER];
    tmr_sel = chip_sel & bus_i.section_select_n & addr[RIOT_A_TIMER];
    tmr_wr = tmr_sel & ~bus_i.read_not_write & addr[RIOT_A_LOAD];
    edg_wr = tmr_sel & ~bus_i.read_not_write & ~addr[RIOT_A_LOAD];
    tmr_rd = tmr_sel & bus_i.read_not_write & ~addr[RIOT_A_SEL];
    flg_rd = tmr_sel & bus_i.read_not_write & addr[RIOT_A_SEL];
    io_wr = io_sel & ~bus_i.read_not_write;
  end

  // RAM array, written synchronously, no reset needed
  logic [RIOT_DATA_W-1:0] ram_mem [RAM_DEPTH];

  // RAM write port
  always_ff @(posedge ref_clk_i) begin
    if (ram_sel && !bus_i.read_not_write) begin
      ram_mem[addr] <= bus_i.wdata;
    end
  end

  // port registers as one array indexed by the low address bits
  logic [RIOT_DATA_W-1:0] preg_reg [4];
  logic [RIOT_DATA_W-1:0] preg_next [4];

  // one generate loop covers the four port registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_preg
      always_comb begin
        preg_next[gi] = preg_reg[gi];
        if (io_wr && addr[RIOT_A_HI:RIOT_A_SEL] == 2'(gi)) begin
          preg_next[gi] = bus_i.wdata;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          preg_reg[gi] <= RIOT_REG_RST;
        end else begin
          preg_reg[gi] <= preg_next[gi];
        end
      end
    end
  endgenerate

  // timer and interrupt state
  logic [7:0] cnt_reg, cnt_next; // interval count
  logic [RIOT_PRE_W-1:0] pre_reg, pre_next; // prescale counter
  logic [RIOT_PRE_W-1:0] pmax_reg, pmax_next; // prescale terminal value
  logic expired_reg, expired_next; // counting at divide by one
  logic tflag_reg, tflag_next; // timer flag, bit 7
  logic tien_reg, tien_next; // timer interrupt enable
  logic eflag_reg, eflag_next; // edge flag, bit 6
  logic eien_reg, eien_next; // edge interrupt enable
  logic epos_reg, epos_next; // edge polarity, 1 rising
  logic pa7_reg, pa7_next; // last port A line7 level
  logic tick; // count step this cycle
  logic timeout; // count passes zero this cycle, first time since load or reset
  logic edge_hit; // selected transition seen

  // timer, flags and edge detector next state
  always_comb begin
    cnt_next = cnt_reg;
    pre_next = pre_reg;
    pmax_next = pmax_reg;
    expired_next = expired_reg;
    tflag_next = tflag_reg;
    tien_next = tien_reg;
    eflag_next = eflag_reg;
    eien_next = eien_reg;
    epos_next = epos_reg;
    pa7_next = port_a_i[7];
    // after timeout the prescaler is bypassed
    tick = expired_reg | (pre_reg == pmax_reg);
    timeout = tick & (cnt_reg == RIOT_CNT_ZERO) & ~expired_reg;
    // pin level is sensed whatever the direction bit says
    edge_hit = epos_reg ? (~pa7_reg & port_a_i[7]) : (pa7_reg & ~port_a_i[7]);
    if (tick) begin
      pre_next = RIOT_PRE_M1;
      cnt_next = cnt_reg - 8'h01; // zero wraps to all ones
    end else begin
      pre_next = pre_reg + 10'h001;
    end
    if (timeout) begin
      expired_next = 1'b1;
    end
    // clears first, so a same-cycle set below wins over a read, not over a load
    if (tmr_rd || tmr_wr) begin
      tflag_next = 1'b0;
      tien_next = addr[RIOT_A_IRQEN];
    end
    if (tmr_wr) begin
      cnt_next = bus_i.wdata;
      pre_next = RIOT_PRE_M1;
      expired_next = 1'b0;
      case (addr[RIOT_A_HI:RIOT_A_SEL])
        RIOT_DIV1: pmax_next = RIOT_PRE_M1;
        RIOT_DIV8: pmax_next = RIOT_PRE_M8;
        RIOT_DIV64: pmax_next = RIOT_PRE_M64;
        RIOT_DIV1024: pmax_next = RIOT_PRE_M1024;
        default: pmax_next = RIOT_PRE_M1;
      endcase
    end
    // a timeout is kept against a read that clears, but dropped by a same-cycle timer load
    if (timeout && !tmr_wr) begin
      tflag_next = 1'b1;
    end
    if (flg_rd) begin
      eflag_next = 1'b0;
    end
    if (edg_wr) begin
      eien_next = addr[RIOT_A_HI]; // data lines ignored
      epos_next = addr[RIOT_A_SEL];
    end
    if (edge_hit) begin
      eflag_next = 1'b1;
    end
  end

  // timer state registers; reset leaves the edge flag alive
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= RIOT_CNT_RST;
      pre_reg <= RIOT_PRE_M1;
      pmax_reg <= RIOT_PRE_M1;
      expired_reg <= 1'b0;
      tflag_reg <= 1'b0;
      tien_reg <= 1'b0;
      eien_reg <= 1'b0;
      epos_reg <= 1'b0; // falling edge
      eflag_reg <= eflag_next; // falling edges still set it
    end else begin
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      pmax_reg <= pmax_next;
      expired_reg <= expired_next;
      tflag_reg <= tflag_next;
      tien_reg <= tien_next;
      eien_reg <= eien_next;
      epos_reg <= epos_next;
      eflag_reg <= eflag_next;
    end
    pa7_reg <= pa7_next; // plain delay, no reset needed
  end

  // read data, pins and interrupt, all registered
  logic [RIOT_DATA_W-1:0] rdata_next;
  logic rdoe_next;
  logic irq_next;

  // output next values
  always_comb begin
    rdata_next = RIOT_REG_RST;
    rdoe_next = chip_sel & bus_i.read_not_write;
    if (ram_sel) begin
      rdata_next = ram_mem[addr];
    end else if (io_sel) begin
      case (addr[RIOT_A_HI:RIOT_A_SEL])
        // port A reads the pins themselves
        RIOT_REG_PA_OUT: rdata_next = port_a_i;
        // port B reads its register so loaded pins do not lie
        RIOT_REG_PB_OUT: rdata_next = preg_reg[RIOT_REG_PB_OUT];
        default: rdata_next = preg_reg[addr[RIOT_A_HI:RIOT_A_SEL]];
      endcase
    end else if (tmr_rd) begin
      rdata_next = cnt_reg;
    end else if (flg_rd) begin
      rdata_next[RIOT_FLAG_TIMER] = tflag_reg;
      rdata_next[RIOT_FLAG_EDGE] = eflag_reg;
    end
    irq_next = (tflag_next & tien_next) | (eflag_next & eien_next);
  end

  // output registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= RIOT_REG_RST;
      rdata_oe_o <= 1'b0;
      port_a_o <= '0;
      port_b_o <= '0;
      irq_oe_o <= 1'b0;
      irq_n_o <= 1'b0; // open drain: only the enable moves
    end else begin
      rdata_o <= rdata_next;
      rdata_oe_o <= rdoe_next;
      port_a_o.out <= preg_next[RIOT_REG_PA_OUT];
      port_a_o.oe <= preg_next[RIOT_REG_PA_DIR];
      port_b_o.out <= preg_next[RIOT_REG_PB_OUT];
      port_b_o.oe <= preg_next[RIOT_REG_PB_DIR];
      irq_oe_o <= irq_next;
      irq_n_o <= 1'b0; // open drain: only the enable moves
    end
  end

  // timeout must raise the flag next cycle, read or not
  AST_TIMEOUT_FLAG: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    timeout && !tmr_wr |=> tflag_reg) else $error("timeout flag not set");
  AST_TIMER_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (tmr_rd || tmr_wr) && !timeout |=> !tflag_reg) else $error("timer flag kept");
  AST_EDGE_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    flg_rd && !edge_hit |=> !eflag_reg) else $error("edge flag kept");
  AST_EDGE_SET: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    edge_hit |=> eflag_reg) else $error("edge lost");
  AST_TIEN: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    tmr_rd |=> tien_reg == $past(addr[RIOT_A_IRQEN])) else $error("enable wrong");
  // wrapped to all ones, next step one clock later unless the host reloads
  sequence s_wrapped;
    cnt_reg == RIOT_CNT_RST && (tmr_wr || cnt_next == RIOT_CNT_RST - 8'h01);
  endsequence
  AST_WRAP: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    timeout && !tmr_wr |=> s_wrapped) else $error("no wrap");
  AST_IRQ: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (tflag_reg && tien_reg) || (eflag_reg && eien_reg) |-> irq_oe_o) else $error("irq idle");
  AST_RESET_EDGE: assert property (
    @(posedge ref_clk_i)
    !rstn_i |=> !eien_reg && !epos_reg) else $error("reset edge setup");
endmodule : riot_core

// ### core/riot_pkg.sv
/*
  riot_pkg: constants, field positions and carrier types for the RAM, I/O and
  interval timer block. Assumes a single 125 MHz system clock that stands in
  for the host bus phase-two clock.
*/
package riot_pkg;
  localparam int RIOT_DATA_W = 8; // data bus width
  localparam int RIOT_ADDR_W = 7; // byte address lines
  localparam int RIOT_RAM_DEPTH = 128; // RAM bytes
  // address bit positions
  localparam int RIOT_A_SEL = 0; // register / edge polarity select
  localparam int RIOT_A_HI = 1; // register / edge enable select
  localparam int RIOT_A_TIMER = 2; // timer versus I/O select
  localparam int RIOT_A_IRQEN = 3; // timer interrupt enable
  localparam int RIOT_A_LOAD = 4; // timer load versus edge control
  // I/O register encodings on the low two address bits
  localparam logic [1:0] RIOT_REG_PA_OUT = 2'h0;
  localparam logic [1:0] RIOT_REG_PA_DIR = 2'h1;
  localparam logic [1:0] RIOT_REG_PB_OUT = 2'h2;
  localparam logic [1:0] RIOT_REG_PB_DIR = 2'h3;
  // prescale select codes and their divide ratios
  localparam logic [1:0] RIOT_DIV1 = 2'h0;
  localparam logic [1:0] RIOT_DIV8 = 2'h1;
  localparam logic [1:0] RIOT_DIV64 = 2'h2;
  localparam logic [1:0] RIOT_DIV1024 = 2'h3;
  localparam int RIOT_PRE_W = 10; // prescaler width, covers divide by 1024
  localparam logic [RIOT_PRE_W-1:0] RIOT_PRE_M1 = 10'h000;
  localparam logic [RIOT_PRE_W-1:0] RIOT_PRE_M8 = 10'h007;
  localparam logic [RIOT_PRE_W-1:0] RIOT_PRE_M64 = 10'h03F;
  localparam logic [RIOT_PRE_W-1:0] RIOT_PRE_M1024 = 10'h3FF;
  // flag register bit positions
  localparam int RIOT_FLAG_TIMER = 7;
  localparam int RIOT_FLAG_EDGE = 6;
  // reset values
  localparam logic [7:0] RIOT_REG_RST = 8'h00;
  localparam logic [7:0] RIOT_CNT_RST = 8'hFF;
  localparam logic [7:0] RIOT_CNT_ZERO = 8'h00;

  // host bus request bundle
  typedef struct packed {
    logic chip_select_high;
    logic chip_select_low_n;
    logic section_select_n; // high selects I/O and timer, low the RAM
    logic read_not_write;
    logic [RIOT_ADDR_W-1:0] byte_address_lines;
    logic [RIOT_DATA_W-1:0] wdata;
  } riot_bus_s;

  // port pin pair: output and enable
  typedef struct packed {
    logic [RIOT_DATA_W-1:0] out;
    logic [RIOT_DATA_W-1:0] oe;
  } riot_port_s;
endpackage : riot_pkg

// ### sim/ram_io_timer_decode_irq_tb.sv
/*
  ram_io_timer_decode_irq_tb: self-checking bench for riot_core with a
  reference model of RAM and port registers, fixed checks of edge and timer flag.
  Assumes riot_pkg, riot_core and riot_host are compiled first.
*/
`timescale 1ns/1ps
module ram_io_timer_decode_irq_tb;
  import riot_pkg::*;
  logic ref_clk_i, rstn_i, access_i, rdata_oe_o, irq_n_o, irq_oe_o, got;
  riot_bus_s bus_i;
  logic [7:0] port_a_i, port_b_i, pa_ext, rdata_o, rv, d;
  riot_port_s port_a_o, port_b_o;
  int err_total, compares;
  logic [31:0] seed;
  int ram_m [int]; // model RAM
  logic [7:0] reg_m [4]; // model port registers
  // pin wire: driven bits follow the port, the rest the outside world
  assign port_a_i = (port_a_o.oe & port_a_o.out) | (~port_a_o.oe & pa_ext);
  riot_core DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .access_i(access_i),
    .bus_i(bus_i), .port_a_i(port_a_i), .port_b_i(port_b_i), .rdata_o(rdata_o),
    .rdata_oe_o(rdata_oe_o), .port_a_o(port_a_o), .port_b_o(port_b_o),
    .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));
  riot_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .rdata_oe_i(rdata_oe_o),
    .access_o(access_i), .bus_o(bus_i));
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string s);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e, input string s);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %b exp %b", $time, s, g, e);
    end
  endtask : chk1
  task automatic wr(input logic sect, input logic [6:0] a, input logic [7:0] v);
    host.xfer(1'b0, sect, 1'b0, a, v, rv, got);
  endtask : wr
  task automatic rd(input logic sect, input logic [6:0] a);
    host.xfer(1'b1, sect, 1'b0, a, 8'h00, rv, got);
    chk1(got, 1'b1, "read answer");
  endtask : rd
  task automatic close_out();
    $display("counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // 125 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // hang guard
  initial begin
    #800000;
    err_total++;
    close_out();
  end
  initial begin : main
    int t, hit, ratio;
    logic [1:0] cc;
    logic ien;
    rstn_i = 1'b0;
    seed = 67;
    pa_ext = 8'hFF;
    err_total = 0;
    compares = 0;
    port_b_i = rnd8();
    repeat (12) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    // reset state: falling edge sets flag only, rising edge ignored
    pa_ext = 8'h7F;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk1(irq_oe_o, 1'b0, "edge irq off");
    rd(1'b1, 7'h05);
    chk8(rv & 8'h40, 8'h40, "edge flag set");
    pa_ext = 8'hFF;
    rd(1'b1, 7'h05);
    chk8(rv & 8'h40, 8'h00, "edge flag cleared, rising ignored");
    $display("test reset_edge done");
    // RAM bytes, deselected accesses refused
    for (int i = 0; i < 4; i++) begin
      d = rnd8();
      ram_m[i * 42] = d;
      wr(1'b0, 7'(i * 42), d);
      host.xfer(1'b0, 1'b0, 1'b1, 7'(i * 42), ~d, rv, got);
      host.xfer(1'b1, 1'b0, 1'b1, 7'(i * 42), 8'h00, rv, got);
      chk1(got, 1'b0, "deselected read");
    end
    for (int r = 0; r < 4; r++) begin
      d = rnd8();
      reg_m[r] = d;
      wr(1'b1, 7'(r), d);
    end
    for (int i = 0; i < 4; i++) begin
      rd(1'b0, 7'(i * 42));
      chk8(rv, 8'(ram_m[i * 42]), "ram byte");
    end
    $display("test ram done");
    // port registers: A output reads the pins, the rest read back
    pa_ext = rnd8();
    for (int r = 0; r < 4; r++) begin
      rd(1'b1, 7'(r));
      d = (r == 0) ? ((reg_m[1] & reg_m[0]) | (~reg_m[1] & pa_ext)) : reg_m[r];
      chk8(rv, d, "port register");
    end
    chk8(port_a_o.oe & port_a_o.out, reg_m[1] & reg_m[0], "port a drive");
    chk8(port_b_o.oe & port_b_o.out, reg_m[3] & reg_m[2], "port b drive");
    $display("test ports done");
    // rising edge made by the port itself driving line 7
    wr(1'b1, 7'h01, 8'h80);
    wr(1'b1, 7'h00, 8'h00);
    rd(1'b1, 7'h05);
    wr(1'b1, 7'h07, rnd8());
    wr(1'b1, 7'h00, 8'h80);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk1(irq_oe_o, 1'b1, "edge irq");
    chk1(irq_n_o, 1'b0, "irq wire level");
    rd(1'b1, 7'h05);
    chk8(rv & 8'h40, 8'h40, "edge flag");
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk1(irq_oe_o, 1'b0, "irq after flag read");
    wr(1'b1, 7'h05, 8'h00);
    wr(1'b1, 7'h00, 8'h00);
    wr(1'b1, 7'h00, 8'h80);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk1(irq_oe_o, 1'b0, "edge irq disabled");
    rd(1'b1, 7'h05);
    chk8(rv & 8'h40, 8'h40, "edge flag while disabled");
    wr(1'b1, 7'h01, 8'h00);
    $display("test edge done");
    // mid-run reset: edge irq off, falling polarity, falls during reset flagged
    pa_ext = 8'hFF;
    wr(1'b1, 7'h07, 8'h00);
    rd(1'b1, 7'h05);
    rstn_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 pa_ext = 8'h7F;
    repeat (9) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk1(irq_oe_o, 1'b0, "edge irq off after reset");
    rd(1'b1, 7'h05);
    chk8(rv & 8'h40, 8'h40, "edge flag set in reset");
    $display("test mid_reset done");
    // timer: every prescale, interrupt on except at divide by 8, where it is off
    for (int c = 0; c < 4; c++) begin
      cc = c[1:0];
      ratio = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 1024;
      ien = (c != 1);
      wr(1'b1, {3'b001, ien, 1'b1, cc}, 8'h02);
      t = 0;
      hit = -1;
      while (t < 3 * ratio + 8) begin
        @(posedge ref_clk_i);
        #1;
        t++;
        if (irq_oe_o === 1'b1 && hit < 0) hit = t;
      end
      if (ien) chk1(hit == 3 * ratio, 1'b1, "timeout time");
      else chk1(hit < 0, 1'b1, "timer irq blocked");
      rd(1'b1, 7'h05);
      chk8(rv & 8'h80, 8'h80, "timer flag");
      rd(1'b1, 7'h04);
      chk8(rv, 8'hF4, "count 11 clocks after wrap");
      rd(1'b1, 7'h05);
      chk8(rv & 8'h80, 8'h00, "timer flag cleared");
      chk1(irq_oe_o, 1'b0, "irq released");
    end
    $display("test timer done");
    close_out();
  end
endmodule : ram_io_timer_decode_irq_tb

// ### sim/riot_host.sv
/*
  riot_host: behavioural host processor on the parallel select, address,
  read/write and data lines of riot_core.
  Assumes ref_clk_i stands in for the phase-two clock; one access at a time.
*/
`timescale 1ns/1ps
module riot_host (
  input wire logic ref_clk_i,
  input wire logic [riot_pkg::RIOT_DATA_W-1:0] rdata_i,
  input wire logic rdata_oe_i,
  output logic access_o,
  output riot_pkg::riot_bus_s bus_o
);
  import riot_pkg::*;
  // bus idle until the first access
  initial begin
    access_o = 1'b0;
    bus_o = '0;
  end
  // one host cycle: hold through the taken edge, release, take the answer
  task automatic xfer(input logic rd, input logic sect, input logic csl_n,
      input logic [6:0] adr, input logic [7:0] wd, output logic [7:0] rd_o,
      output logic got);
    @(posedge ref_clk_i);
    #1;
    access_o = 1'b1;
    bus_o = {1'b1, csl_n, sect, rd, adr, wd};
    @(posedge ref_clk_i);
    #1;
    access_o = 1'b0;
    // released address and data lines must not keep their last value
    bus_o.byte_address_lines = ~adr;
    bus_o.wdata = ~wd;
    got = rdata_oe_i;
    rd_o = rdata_i;
  endtask : xfer
endmodule : riot_host
